// ==== include/pps_pkg.sv ====
// constants, types and state records for the platform power sequencing glue
// assumes one 100 MHz clock, a synchronous active-low reset and an APB master
package pps_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int DELAY_MIN_MS  = 100;
    localparam int DELAY_MAX_MS  = 120;
    localparam int DELAY_TICKS   = DELAY_MIN_MS;
    localparam int TMR_DIV_W     = 17;
    localparam int TMR_MS_W      = 7;

    // register map, printed offsets are word indexes
    localparam int           ADDR_W      = 12;
    localparam logic [7:0]   WAKE_IDX    = 8'h16;
    localparam logic [7:0]   LOCK_IDX    = 8'h20;
    localparam logic [7:0]   STAT_IDX    = 8'h21;
    localparam logic [11:0]  WAKE_ADDR   = {2'h0, WAKE_IDX, 2'h0};
    localparam logic [11:0]  LOCK_ADDR   = {2'h0, LOCK_IDX, 2'h0};
    localparam logic [11:0]  STAT_ADDR   = {2'h0, STAT_IDX, 2'h0};
    localparam logic [7:0]   WAKE_RESET  = 8'h80;
    localparam int           SEL_LSB     = 2;
    localparam int           SEL_MSB     = 3;
    localparam logic [1:0]   SEL_DELAYED = 2'h0;
    localparam logic [1:0]   SEL_NODELAY = 2'h1;
    localparam int           LOCK_BIT    = 0;
    localparam logic [31:0]  RD_ZERO     = 32'h0;

    // status bit positions
    localparam int STAT_PPG    = 0;
    localparam int STAT_WAIT   = 1;
    localparam int STAT_LATCH  = 2;
    localparam int STAT_REGSW  = 3;
    localparam int STAT_W      = 4;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_WAIT = 3'b010,
        ST_ON   = 3'b100
    } pps_state_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } pps_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pps_apb_rsp_s;

    typedef struct packed {
        pps_state_e  state;
        logic [7:0]  wake;
        logic        lock;
        logic        ppg;
        logic        guard_oe;
        logic        regsw_oe;
        logic        latched;
        logic        rsn_prev;
        logic        pg_prev;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pps_core_s;

    typedef struct packed {
        logic [TMR_DIV_W-1:0] div;
        logic [TMR_MS_W-1:0]  ms;
        logic                 done;
    } pps_tmr_s;

endpackage

// ==== core/pps_delay_timer.sv ====
// power good delay timer: a 1 ms enable divider and a millisecond counter
// assumes run is a level from the sequencer; dropping it clears all counts
`timescale 1ns/1ps
module pps_delay_timer import pps_pkg::*; #(
    parameter int TICK_LEN  = TICK_CYCLES,
    parameter int TICK_NUM  = DELAY_TICKS
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // control
    input  wire logic run,
    output logic      done
);

    localparam logic [TMR_DIV_W-1:0] DIV_LAST = TMR_DIV_W'(TICK_LEN - 1);
    localparam logic [TMR_MS_W-1:0]  MS_LAST  = TMR_MS_W'(TICK_NUM);

    pps_tmr_s st_ff;
    pps_tmr_s nxt_st;
    logic     tick;

    always_comb begin
        nxt_st = st_ff;
        tick   = (st_ff.div == DIV_LAST);
        if (!run) begin
            // divider restarts too, so the delay never comes up short
            nxt_st = '0;
        end else if (!st_ff.done) begin
            nxt_st.div = tick ? '0 : st_ff.div + 1'b1;
            if (tick) begin
                nxt_st.ms = st_ff.ms + 1'b1;
            end
            nxt_st.done = tick && (st_ff.ms + 1'b1 == MS_LAST);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done = st_ff.done;

    a_timer_clear: assert property (@(posedge clk) disable iff (!resetn)
        !run |=> (st_ff.ms == '0) && !done)
        else $error("delay timer not cleared while idle");

endmodule

// ==== core/pps_glue.sv ====
// platform power good sequencer with clock guard and regulator switch outputs
// assumes supply and sleep inputs are synchronous to clk; registers over APB
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module pps_glue import pps_pkg::*; #(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   resetn,
    // register bus
    input  pps_apb_req_s apb_req,
    output pps_apb_rsp_s apb_rsp,
    // sleep state and supply inputs
    input  wire logic   supply_power_good,
    input  wire logic   sleep_s3_n,
    input  wire logic   sleep_s5_n,
    // sequenced outputs
    output logic        platform_power_good,
    output logic        clock_line_guard_gate_o,
    output logic        clock_line_guard_gate_oe,
    output logic        regulator_switch_n_o,
    output logic        regulator_switch_n_oe,
    output logic        latched_regulator_switch
);

    pps_core_s   st_ff;
    pps_core_s   nxt_st;
    logic        tmr_done;
    logic        tmr_run;
    logic        rails_ok;
    logic        pg_rise;
    logic        sel_nodelay;
    logic        regulator_switch_internal;
    logic        sw_rise;
    logic        acc_first;
    logic        acc_commit;
    logic        hit;
    logic [31:0] rd_data;

    // the delay counter only runs in the wait state
    assign tmr_run = (st_ff.state == ST_WAIT);

    pps_delay_timer #(
        .TICK_LEN (TICK_LEN),
        .TICK_NUM (DELAY_TICKS)
    ) u_timer (
        .clk    (clk),
        .resetn (resetn),
        .run    (tmr_run),
        .done   (tmr_done)
    );

    always_comb begin
        rails_ok    = supply_power_good && sleep_s3_n;
        pg_rise     = supply_power_good && !st_ff.pg_prev;
        sel_nodelay = (st_ff.wake[SEL_MSB:SEL_LSB] == SEL_NODELAY);
        // level of the open-drain regulator switch pin, high when released
        regulator_switch_internal = !rails_ok;
        sw_rise     = regulator_switch_internal && !st_ff.rsn_prev;
        acc_first   = apb_req.psel && apb_req.penable && !st_ff.pready;
        acc_commit  = apb_req.psel && apb_req.penable && st_ff.pready;
        hit         = (apb_req.paddr == WAKE_ADDR) || (apb_req.paddr == LOCK_ADDR)
                      || (apb_req.paddr == STAT_ADDR);

        case (apb_req.paddr)
            WAKE_ADDR: begin
                rd_data = {24'h0, st_ff.wake};
            end
            LOCK_ADDR: begin
                rd_data = {31'h0, st_ff.lock};
            end
            STAT_ADDR: begin
                rd_data = {28'h0, st_ff.regsw_oe, st_ff.latched, tmr_run, st_ff.ppg};
            end
            default: begin
                rd_data = RD_ZERO;
            end
        endcase

        nxt_st = st_ff;

        // sequencer
        if (!rails_ok) begin
            nxt_st.state = ST_OFF;
        end else begin
            case (st_ff.state)
                ST_OFF: begin
                    if (pg_rise) begin
                        nxt_st.state = sel_nodelay ? ST_ON : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (tmr_done) begin
                        nxt_st.state = ST_ON;
                    end
                end
                ST_ON: begin
                    nxt_st.state = ST_ON;
                end
                default: begin
                    nxt_st.state = ST_OFF;
                end
            endcase
        end
        nxt_st.ppg      = (nxt_st.state == ST_ON);
        nxt_st.guard_oe = nxt_st.ppg;
        nxt_st.regsw_oe = rails_ok;
        nxt_st.pg_prev  = supply_power_good;
        nxt_st.rsn_prev = regulator_switch_internal;

        // latched switch; rsn_prev resets released so power-up shows no edge
        if (!sleep_s5_n) begin
            nxt_st.latched = 1'b0;
        end else if (sw_rise) begin
            nxt_st.latched = 1'b1;
        end else if (!regulator_switch_internal) begin
            nxt_st.latched = 1'b0;
        end else begin
            nxt_st.latched = st_ff.latched;
        end

        // apb: one wait state, answer registered
        nxt_st.pready  = 1'b0;
        nxt_st.pslverr = 1'b0;
        if (acc_first) begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = !hit;
            nxt_st.prdata  = apb_req.pwrite ? st_ff.prdata : rd_data;
        end
        if (acc_commit && apb_req.pwrite) begin
            if (apb_req.paddr == WAKE_ADDR) begin
                nxt_st.wake[7:SEL_MSB+1]     = apb_req.pwdata[7:SEL_MSB+1];
                nxt_st.wake[SEL_LSB-1:0]     = apb_req.pwdata[SEL_LSB-1:0];
                if (!st_ff.lock) begin
                    nxt_st.wake[SEL_MSB:SEL_LSB] = apb_req.pwdata[SEL_MSB:SEL_LSB];
                end
            end
            if (apb_req.paddr == LOCK_ADDR) begin
                // the lock only sets; reset is the only way back
                nxt_st.lock = st_ff.lock | apb_req.pwdata[LOCK_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff          <= '0;
            st_ff.state    <= ST_OFF;
            st_ff.wake     <= WAKE_RESET;
            st_ff.rsn_prev <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign apb_rsp.pready           = st_ff.pready;
    assign apb_rsp.pslverr          = st_ff.pslverr;
    assign apb_rsp.prdata           = st_ff.prdata;
    assign platform_power_good      = st_ff.ppg;
    assign clock_line_guard_gate_o  = 1'b0;
    assign clock_line_guard_gate_oe = st_ff.guard_oe;
    assign regulator_switch_n_o     = 1'b0;
    assign regulator_switch_n_oe    = st_ff.regsw_oe;
    assign latched_regulator_switch = st_ff.latched;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_rails_lost;
        !sleep_s3_n || !supply_power_good;
    endsequence

    sequence s_qual_rise;
        rails_ok && pg_rise && (st_ff.state == ST_OFF);
    endsequence

    sequence s_wake_write;
        acc_commit && apb_req.pwrite && (apb_req.paddr == WAKE_ADDR);
    endsequence

    a_drop_power_good: assert property (
        s_rails_lost |=> !platform_power_good && !clock_line_guard_gate_oe)
        else $error("power good not dropped on rail loss");

    a_immediate_rise: assert property (
        s_qual_rise ##0 sel_nodelay |=> platform_power_good)
        else $error("no-delay select did not raise power good");

    a_delayed_start: assert property (
        s_qual_rise ##0 !sel_nodelay |=> !platform_power_good && tmr_run)
        else $error("delayed select raised power good early");

    a_reset_default: assert property (
        $rose(resetn) |-> st_ff.wake[SEL_MSB:SEL_LSB] == SEL_DELAYED)
        else $error("delay select default is not delayed");

    a_rise_cause: assert property (
        $rose(platform_power_good) |-> $past(tmr_done) || $past(sel_nodelay))
        else $error("power good rose without timer or no-delay select");

    a_sel_write: assert property (
        s_wake_write ##0 !st_ff.lock |=>
            st_ff.wake[SEL_MSB:SEL_LSB] == $past(apb_req.pwdata[SEL_MSB:SEL_LSB]))
        else $error("delay select write not stored");

    a_guard_follow: assert property (
        clock_line_guard_gate_oe == platform_power_good)
        else $error("guard gate does not follow power good");

    a_switch_drive: assert property (
        rails_ok |=> regulator_switch_n_oe ##0 !regulator_switch_n_o)
        else $error("regulator switch not pulled low");

    a_switch_float: assert property (
        !rails_ok |=> !regulator_switch_n_oe)
        else $error("regulator switch driven outside both-high case");

    a_latch_clear: assert property (
        !sleep_s5_n |=> !latched_regulator_switch)
        else $error("latched switch not forced low by S5");

    a_latch_set: assert property (
        sleep_s5_n && sw_rise |=> latched_regulator_switch)
        else $error("latched switch missed rising edge");

    a_latch_hold: assert property (
        sleep_s5_n && regulator_switch_internal && st_ff.rsn_prev
            |=> latched_regulator_switch == $past(latched_regulator_switch))
        else $error("latched switch changed without edge");

    a_powerup_low: assert property (
        $rose(resetn) ##0 regulator_switch_internal [*2] |-> !latched_regulator_switch)
        else $error("latched switch rose during power-up");

    a_count_clear: assert property (
        s_rails_lost |=> !tmr_run)
        else $error("delay counter kept running without rails");

    a_lock_holds: assert property (
        s_wake_write ##0 st_ff.lock |=>
            st_ff.wake[SEL_MSB:SEL_LSB] == $past(st_ff.wake[SEL_MSB:SEL_LSB]))
        else $error("locked delay select was overwritten");

endmodule

// ==== bench/pps_partner.sv ====
// model of the chipset sleep outputs and the supply power good line
// assumes the bench calls its tasks from a single thread, right after clock edges
`timescale 1ns/1ps
module pps_partner #(
    parameter int GAP = 10,
    parameter int T3  = 6
) (
    // clock
    input  wire logic clk,
    // sleep state and supply outputs
    output logic      supply_power_good,
    output logic      sleep_s3_n,
    output logic      sleep_s5_n
);
    initial begin
        supply_power_good = 1'b0;
        sleep_s3_n        = 1'b0;
        sleep_s5_n        = 1'b0;
    end

    // s5 first; the switch only turns active once s3 and supply good are both up
    task automatic power_on();
        @(posedge clk);
        sleep_s5_n <= 1'b1;
        repeat (GAP) @(posedge clk);
        sleep_s3_n <= 1'b1;
        @(posedge clk);
        supply_power_good <= 1'b1;
    endtask

    // normal power-down: s5 follows s3 after a short fixed gap
    task automatic sleep_s3();
        @(posedge clk);
        sleep_s3_n <= 1'b0;
        repeat (T3) @(posedge clk);
        sleep_s5_n <= 1'b0;
        @(posedge clk);
        supply_power_good <= 1'b0;
    endtask

    // supply good dips for a few cycles, then recovers
    task automatic supply_pulse(input int low);
        @(posedge clk);
        supply_power_good <= 1'b0;
        repeat (low) @(posedge clk);
        supply_power_good <= 1'b1;
    endtask
endmodule

// ==== bench/pps_glue_tb.sv ====
// self-checking bench for the power sequencing glue
// assumes a pull-up on both open-drain pins and a 10 cycle millisecond tick
`timescale 1ns/1ps
module pps_glue_tb;
    import pps_pkg::*;
    localparam int TL    = 10;
    localparam int LIMIT = 20000;

    logic         clk;
    logic         resetn;
    pps_apb_req_s apb_req;
    pps_apb_rsp_s apb_rsp;
    logic         pg, s3_n, s5_n, ppg, g_o, g_oe, r_o, r_oe, latched;
    logic         guard_pin, regsw_pin;
    int           n_errors, comparisons, cycles;

    assign guard_pin = g_oe ? g_o : 1'b1;
    assign regsw_pin = r_oe ? r_o : 1'b1;

    pps_glue #(.TICK_LEN(TL)) u_pps_glue (
        .clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .supply_power_good(pg), .sleep_s3_n(s3_n), .sleep_s5_n(s5_n),
        .platform_power_good(ppg), .clock_line_guard_gate_o(g_o),
        .clock_line_guard_gate_oe(g_oe), .regulator_switch_n_o(r_o),
        .regulator_switch_n_oe(r_oe), .latched_regulator_switch(latched)
    );

    pps_partner #(.GAP(TL), .T3(6)) u_pps_partner (
        .clk(clk), .supply_power_good(pg), .sleep_s3_n(s3_n), .sleep_s5_n(s5_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // a hang is cut short here and still reaches the closing report
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    // one apb transfer, held until pready is seen high at an edge; only the
    // bench timeout ends a wait that never gets an answer
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (apb_rsp.pready !== 1'b1);
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
        chk(err, eerr);
    endtask

    // cycles from the call until platform power good is seen high
    task automatic wait_ppg(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
            #1;
        end while (ppg !== 1'b1 && n < 2000);
    endtask

    task automatic t_reset();
        chk({ppg, guard_pin, regsw_pin, latched}, 4'h6);
        rd_chk(WAKE_ADDR, {24'h0, WAKE_RESET}, 1'b0);
        rd_chk(STAT_ADDR, 32'h0, 1'b0);
        rd_chk(12'hFFC, 32'h0, 1'b1);
        $display("test reset done");
    endtask

    // a dip in supply good mid-delay must restart the full count
    task automatic t_delayed();
        int n;
        u_pps_partner.power_on();
        repeat (50 * TL) @(posedge clk);
        #1;
        chk(ppg, 1'b0);
        u_pps_partner.supply_pulse(2);
        wait_ppg(n);
        chk(32'(n >= 100 * TL && n <= 120 * TL), 1);
        chk({guard_pin, regsw_pin, latched}, 3'h0);
        $display("test delayed done");
    endtask

    task automatic t_sleep();
        fork
            u_pps_partner.sleep_s3();
            begin
                repeat (4) @(posedge clk);
                #1;
                chk({ppg, guard_pin, regsw_pin, latched}, 4'h7);
            end
        join
        repeat (2) @(posedge clk);
        #1;
        chk(latched, 1'b0);
        $display("test sleep done");
    endtask

    task automatic t_nodelay();
        int n;
        wr(WAKE_ADDR, 32'h84);
        fork
            u_pps_partner.power_on();
            begin
                repeat (4) @(posedge clk);
                #1;
                chk(latched, 1'b0);
            end
        join
        wait_ppg(n);
        chk(32'(n <= 3), 1);
        u_pps_partner.supply_pulse(3);
        #1;
        chk(ppg, 1'b0);
        wait_ppg(n);
        $display("test nodelay done");
    endtask

    // once locked the select bits keep no-delay; other bits still take writes
    task automatic t_lock();
        int n;
        wr(LOCK_ADDR, 32'h1);
        wr(WAKE_ADDR, 32'h40);
        rd_chk(WAKE_ADDR, 32'h44, 1'b0);
        rd_chk(STAT_ADDR, 32'h9, 1'b0);
        u_pps_partner.supply_pulse(3);
        wait_ppg(n);
        chk(32'(n <= 3), 1);
        // a reset in mid-run is the only way to clear the lock
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(LOCK_ADDR, 32'h0, 1'b0);
        rd_chk(WAKE_ADDR, {24'h0, WAKE_RESET}, 1'b0);
        $display("test lock done");
    endtask

    initial begin
        resetn   = 1'b0;
        apb_req  = '0;
        n_errors = 0;
        comparisons = 0;
        cycles   = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_delayed();
        t_sleep();
        t_nodelay();
        t_lock();
        results();
    end
endmodule
